/* rtl/cdf_regs.vh */
// constants of the clock divider / fanout configuration block
// assumes one 100 MHz core clock; each core cycle stands for one input-clock half period
`ifndef CDF_REGS_VH
`define CDF_REGS_VH

// configuration word, bit Dn sits at index n-1
`define CDF_CFG_W 22
`define CDF_CFG_RST 22'h000000
`define CDF_CNT_W 5
// divider select fields, lowest index holds name bit 2
`define CDF_DIV_A_LSB 10
`define CDF_DIV_B_LSB 13
`define CDF_DIV_C_LSB 16
`define CDF_DIV_D_LSB 19
`define CDF_DIV_FIELD_STEP 3
// per-output enables, qa0 first
`define CDF_EN_LSB 2
`define CDF_N_OUT 8
`define CDF_N_BANK 4
// output type bits
`define CDF_TYPE_A_BIT 0
`define CDF_TYPE_BCD_BIT 1
`define CDF_TYPE_LVDS 1'b0
`define CDF_TYPE_LVPECL 1'b1
// divider select codes
`define CDF_DIV_BY1 3'h0
`define CDF_DIV_BY2 3'h1
`define CDF_DIV_BY3 3'h2
`define CDF_DIV_BY4 3'h3
`define CDF_DIV_BY5 3'h4
`define CDF_DIV_BY6 3'h5
`define CDF_DIV_RSVD 3'h6
`define CDF_DIV_BY8 3'h7

`endif

/* rtl/cdf_bank_div.v */
// one bank divider: output period is twice the factor in core cycles
// assumes run_i is already synchronous to ref_clk_i
`include "cdf_regs.vh"

module cdf_bank_div
(
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire ce_i,
	input wire run_i,
	input wire [2:0] div_sel_i,
	output reg div_clk_o
);

	// half period in core cycles minus one, zero for the reserved code
	function [2:0] cdf_half_len;
		input [2:0] sel;
		begin
			case (sel)
				`CDF_DIV_BY1: cdf_half_len = 3'h0;
				`CDF_DIV_BY2: cdf_half_len = 3'h1;
				`CDF_DIV_BY3: cdf_half_len = 3'h2;
				`CDF_DIV_BY4: cdf_half_len = 3'h3;
				`CDF_DIV_BY5: cdf_half_len = 3'h4;
				`CDF_DIV_BY6: cdf_half_len = 3'h5;
				`CDF_DIV_BY8: cdf_half_len = 3'h7;
				default: cdf_half_len = 3'h0;
			endcase
		end
	endfunction

	reg [2:0] cnt_q; // cycles spent in current half period
	reg run_q; // run seen last cycle, for release detection
	wire rsvd = (div_sel_i == `CDF_DIV_RSVD); // reserved code parks output low

	////////////////////////////////////////////////////////////////////////////
	// divider counter and output level
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q <= 3'h0;
			run_q <= 1'b0;
			div_clk_o <= 1'b0;
		end
		else if (ce_i)
		begin
			run_q <= run_i;
			if (!run_i || rsvd)
			begin
				// held in reset or on the reserved code: low, counter cleared
				cnt_q <= 3'h0;
				div_clk_o <= 1'b0;
			end
			else if (!run_q)
			begin
				// release: every bank not on the reserved code goes high on this same edge
				cnt_q <= 3'h0;
				div_clk_o <= 1'b1;
			end
			else if (cnt_q >= cdf_half_len(div_sel_i))
			begin
				// half period done, toggle
				cnt_q <= 3'h0;
				div_clk_o <= ~div_clk_o;
			end
			else
			begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

endmodule // cdf_bank_div

/* rtl/cdf_config.v */
// configuration and control of a 1-to-8 clock divider and fanout buffer
// assumes serial pins and control pins are asynchronous to ref_clk_i
`include "cdf_regs.vh"

module cdf_config
(
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire ce_i,
	input wire sclk_i,
	input wire serial_data_in_i,
	input wire load_strobe_i,
	input wire global_oe_i,
	input wire divider_reset_n_i,
	output reg serial_data_out_o,
	output reg [7:0] out_p_o,
	output reg [7:0] out_n_o,
	output reg [7:0] out_type_o,
	output reg [7:0] out_enabled_o,
	output reg cfg_loaded_o,
	output reg [4:0] bit_count_o
);

	// serial port states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SHIFT = 3'b010;
	localparam [2:0] ST_LOAD = 3'b100;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	reg [4:0] sync1_q; // first stage, read only by sync2_q
	reg [4:0] sync2_q; // second stage, usable
	reg sclk_d1_q; // delayed sclk for edge detect
	reg le_d1_q; // delayed load strobe for edge detect

	wire sclk_s = sync2_q[0];
	wire sdi_s = sync2_q[1];
	wire le_s = sync2_q[2];
	wire oe_s = sync2_q[3];
	wire run_s = sync2_q[4];
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire le_rise = le_s & ~le_d1_q;
	wire le_fall = ~le_s & le_d1_q;

	// synchroniser and edge history
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			sclk_d1_q <= 1'b0;
			le_d1_q <= 1'b0;
		end
		else if (ce_i)
		begin
			sync1_q <= {divider_reset_n_i, global_oe_i, load_strobe_i, serial_data_in_i, sclk_i};
			sync2_q <= sync1_q;
			sclk_d1_q <= sclk_s;
			le_d1_q <= le_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial shift register and active configuration
	reg [`CDF_CFG_W-1:0] shift_q; // incoming word
	reg [`CDF_CFG_W-1:0] active_q; // applied word
	reg loaded_q; // a word has been applied since reset
	reg [2:0] state_q; // serial port state
	reg [2:0] state_d;
	reg [`CDF_CNT_W-1:0] cnt_q; // bits shifted since last load

	// next state of the serial port
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (le_rise)
					state_d = ST_LOAD;
				else if (sclk_rise && !le_s)
					state_d = ST_SHIFT;
			end
			ST_SHIFT:
			begin
				if (le_rise)
					state_d = ST_LOAD;
			end
			ST_LOAD:
			begin
				// strobe high: wait for it to fall
				if (le_fall)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// shift, load and readback reload
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			state_q <= ST_IDLE;
			shift_q <= `CDF_CFG_RST;
			active_q <= `CDF_CFG_RST;
			loaded_q <= 1'b0;
			cnt_q <= {`CDF_CNT_W{1'b0}};
			serial_data_out_o <= 1'b0;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			if (le_rise)
			begin
				// apply the shifted word at the strobe rise
				active_q <= shift_q;
				loaded_q <= 1'b1;
				cnt_q <= {`CDF_CNT_W{1'b0}};
			end
			else if (le_fall)
			begin
				// reload the applied word so the next frame reads it back
				shift_q <= active_q;
			end
			else if (sclk_rise && !le_s)
			begin
				// msb first, D22 ends up at the top after 22 edges
				// active_q untouched here, outputs keep old settings
				shift_q <= {shift_q[`CDF_CFG_W-2:0], sdi_s};
				if (cnt_q != 5'h1f)
					cnt_q <= cnt_q + 5'h01;
			end
			// serial out shows the top bit after every shift
			serial_data_out_o <= shift_q[`CDF_CFG_W-1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bank dividers
	wire [3:0] bank_clk; // divided clock per bank, a..d
	wire [4*3-1:0] bank_sel; // select per bank, {bit2,bit1,bit0}

	genvar gb;
	generate
		for (gb = 0; gb < `CDF_N_BANK; gb = gb + 1)
		begin : g_bank
			// field of three bits, name bit0 at the highest index
			assign bank_sel[gb*3+2:gb*3] = {
				active_q[`CDF_DIV_A_LSB + gb*`CDF_DIV_FIELD_STEP],
				active_q[`CDF_DIV_A_LSB + gb*`CDF_DIV_FIELD_STEP + 1],
				active_q[`CDF_DIV_A_LSB + gb*`CDF_DIV_FIELD_STEP + 2]};

			cdf_bank_div u_div
			(
				.ref_clk_i(ref_clk_i),
				.sys_rst_i(sys_rst_i),
				.ce_i(ce_i),
				.run_i(run_s),
				.div_sel_i(bank_sel[gb*3+2:gb*3]),
				.div_clk_o(bank_clk[gb])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// output enable, type and level per output
	wire [7:0] en_word = active_q[`CDF_EN_LSB+7:`CDF_EN_LSB]; // qa0..qd1
	wire [7:0] en_eff; // enables after pin and load gating
	wire [7:0] type_sel; // configured type per output

	genvar go;
	generate
		for (go = 0; go < `CDF_N_OUT; go = go + 1)
		begin : g_out
			// pin low or never loaded: disabled whatever the bits
			// pin high: own bit decides
			assign en_eff[go] = oe_s & loaded_q & en_word[go];
			// bank a uses D1, the rest D2
			assign type_sel[go] = (go < 2) ? active_q[`CDF_TYPE_A_BIT] :
				active_q[`CDF_TYPE_BCD_BIT];

			// registered pin drive
			always @(posedge ref_clk_i)
			begin
				if (sys_rst_i)
				begin
					out_p_o[go] <= 1'b0;
					out_n_o[go] <= 1'b1;
					out_type_o[go] <= `CDF_TYPE_LVDS;
					out_enabled_o[go] <= 1'b0;
				end
				else if (ce_i)
				begin
					out_enabled_o[go] <= en_eff[go];
					if (en_eff[go])
					begin
						out_p_o[go] <= bank_clk[go/2];
						out_n_o[go] <= ~bank_clk[go/2];
						out_type_o[go] <= type_sel[go];
					end
					else
					begin
						// static low/high in LVDS
						out_p_o[go] <= 1'b0;
						out_n_o[go] <= 1'b1;
						out_type_o[go] <= `CDF_TYPE_LVDS;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// status outputs
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg_loaded_o <= 1'b0;
			bit_count_o <= 5'h00;
		end
		else if (ce_i)
		begin
			cfg_loaded_o <= loaded_q;
			// a full word shows 22 here before the strobe
			bit_count_o <= cnt_q;
		end
	end

endmodule // cdf_config

/* dv/cdf_config_props.sv */
// port assertions of the configuration block
// assumes one clock and ce_i held high
module cdf_config_props
(
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire sclk_i,
	input wire load_strobe_i,
	input wire global_oe_i,
	input wire divider_reset_n_i,
	input wire serial_data_out_o,
	input wire [7:0] out_p_o,
	input wire [7:0] out_n_o,
	input wire [7:0] out_type_o,
	input wire [7:0] out_enabled_o,
	input wire cfg_loaded_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// pins held past the synchronisers
	sequence s_oe_off;
		!global_oe_i [*5];
	endsequence
	sequence s_idle;
		(!sclk_i && !load_strobe_i) [*8];
	endsequence
	chk_off_low: assert property ((~out_enabled_o & out_p_o) == 8'h00)
		else $error("disabled output toggles");
	chk_off_lvds: assert property ((~out_enabled_o & out_type_o) == 8'h00)
		else $error("disabled output not lvds");
	chk_pair_diff: assert property (out_n_o == ~out_p_o)
		else $error("pair not complementary");
	chk_oe_wins: assert property (s_oe_off |-> out_enabled_o == 8'h00)
		else $error("enabled with oe low");
	chk_unloaded_off: assert property (!cfg_loaded_o |-> out_enabled_o == 8'h00)
		else $error("enabled before load");
	chk_div_hold: assert property (!divider_reset_n_i [*6] |-> out_p_o == 8'h00)
		else $error("output runs in reset");
	chk_keep_cfg: assert property ((!load_strobe_i && global_oe_i) [*6]
		|-> $stable(out_enabled_o) && $stable(out_type_o)) else $error("settings moved");
	chk_sdo_hold: assert property (s_idle |-> $stable(serial_data_out_o))
		else $error("readback moved");
endmodule // cdf_config_props

bind cdf_config cdf_config_props u_props
(
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
	.load_strobe_i(load_strobe_i), .global_oe_i(global_oe_i),
	.divider_reset_n_i(divider_reset_n_i), .serial_data_out_o(serial_data_out_o),
	.out_p_o(out_p_o), .out_n_o(out_n_o), .out_type_o(out_type_o),
	.out_enabled_o(out_enabled_o), .cfg_loaded_o(cfg_loaded_o)
);

/* dv/cdf_ctl_model.sv */
// serial controller model for the configuration port
// assumes pins change just after a clock edge
module cdf_ctl_model
(
	input wire ref_clk_i,
	input wire serial_data_out_i,
	output logic sclk_o,
	output logic serial_data_in_o,
	output logic strobe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// pulled-down pins idle low
	initial {sclk_o, serial_data_in_o, strobe_o} = 3'h0;
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// whole word, top bit first, readback sampled before each rise
	task automatic xfer(input logic [21:0] w, output logic [21:0] rd);
		for (int i = 21; i >= 0; i--)
		begin
			serial_data_in_o <= w[i];
			wt(4);
			rd[i] = serial_data_out_i;
			sclk_o <= 1'b1;
			wt(4);
			sclk_o <= 1'b0;
		end
		serial_data_in_o <= 1'b0;
		wt(4);
		strobe_o <= 1'b1;
		wt(4);
		strobe_o <= 1'b0;
		wt(8);
	endtask
endmodule // cdf_ctl_model

/* dv/clock_divider_fanout_config_tb.sv */
// bench for the configuration block
// assumes the controller model drives the serial pins
module clock_divider_fanout_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i, sys_rst_i, oe, rn, sclk, sdi, lds, sdo;
	logic [7:0] p, typ, en, lp;
	logic [21:0] w, rd;
	logic [4:0] bc;
	logic ld;
	logic [31:0] rng = 32'hd;
	logic [21:0] q[$] = '{22'h0};
	int n_mismatch = 0;
	int samples_checked = 0;
	int first[8], per[8];
	cdf_config dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .sclk_i(sclk),
		.serial_data_in_i(sdi), .load_strobe_i(lds), .global_oe_i(oe), .divider_reset_n_i(rn),
		.serial_data_out_o(sdo), .out_p_o(p), .out_n_o(), .out_type_o(typ),
		.out_enabled_o(en), .cfg_loaded_o(ld), .bit_count_o(bc));
	cdf_ctl_model ctl (.ref_clk_i(ref_clk_i), .serial_data_out_i(sdo), .sclk_o(sclk),
		.serial_data_in_o(sdi), .strobe_o(lds));
	////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// bank select field, top index holds bit 0
	function automatic logic [2:0] code(input logic [21:0] v, input int b);
		return {v[10 + 3 * b], v[11 + 3 * b], v[12 + 3 * b]};
	endfunction
	// divide factor, reserved gives 0
	function automatic int fac(input logic [2:0] c);
		return (c == 3'h6) ? 0 : (c == 3'h7) ? 8 : int'(c) + 1;
	endfunction
	task automatic wt(input int k);
		repeat (k) @(posedge ref_clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// hang guard
	initial
	begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		int r;
		{sys_rst_i, oe, rn} = 3'h5;
		wt(20);
		sys_rst_i <= 1'b0;
		oe <= 1'b1;
		wt(6);
		chk("enabled", 0, en);
		chk("loaded", 0, ld);
		chk("bit_count", 0, bc);
		// one bank A code per pass, qa0 enabled, rest random
		for (int k = 0; k < 8; k++)
		begin
			rng = xs(rng);
			w = {rng[21:13], k[0], k[1], k[2], rng[9:3], 1'b1, rng[1:0]};
			ctl.xfer(w, rd);
			chk("readback", q.pop_front(), rd);
			q.push_back(w);
			chk("loaded", 1, ld);
			chk("bit_count", 0, bc);
			chk("enabled", w[9:2], en);
			chk("type", {{6{w[1]}}, {2{w[0]}}} & w[9:2], typ);
			rn <= 1'b0;
			wt(6);
			rn <= 1'b1;
			first = '{default: -1};
			per = '{default: 0};
			// rising edges seen per output
			for (int c = 0; c < 40; c++)
			begin
				lp = p;
				@(negedge ref_clk_i);
				for (int i = 0; i < 8; i++)
				begin
					if (p[i] && !lp[i] && first[i] >= 0 && per[i] == 0)
						per[i] = c - first[i];
					if (p[i] && !lp[i] && first[i] < 0)
						first[i] = c;
				end
			end
			r = -1;
			for (int i = 0; i < 8; i++)
				if (w[2 + i])
				begin
					chk("period", 2 * fac(code(w, i / 2)), per[i]);
					if (r < 0 && per[i] > 0)
						r = first[i];
					if (per[i] > 0)
						chk("start", r, first[i]);
				end
			wt(1);
			oe <= 1'b0;
			wt(5);
			chk("oe_low", 0, {p, en, typ});
			oe <= 1'b1;
			wt(5);
		end
		end_of_test();
	end
endmodule // clock_divider_fanout_config_tb
